//--- verilog/reset_cause_pkg.sv
package reset_cause_pkg;

    // register map, byte addresses on the avalon slave
    localparam logic [15:0] CAUSE_STATUS_ADDR  = 16'hf00c;
    localparam logic [15:0] SUPERVISOR_MODE_ADDR = 16'hf010;
    localparam logic [15:0] BLOCK_CONTROL_45_ADDR = 16'hf06c;
    localparam logic [15:0] RESET_CONTROL_ADDR = 16'hf014;

    // cause flag positions
    localparam int POWER_ON_BIT  = 0;
    localparam int WATCHDOG_BIT  = 2;
    localparam int SUPERVISOR_BIT = 3;
    localparam int DETECTOR_BIT  = 4;
    localparam logic [7:0] CAUSE_MASK = 8'h1d;

    // enable bit positions
    localparam int SUPERVISOR_ENABLE_BIT = 0;
    localparam int DETECTOR_DISABLE_BIT  = 2;

    // reset values
    localparam logic [7:0] SUPERVISOR_MODE_RESET = 8'h00;
    localparam logic [7:0] BLOCK_CONTROL_45_RESET = 8'h04;
    localparam logic [7:0] CAUSE_POWER_ON_VALUE = 8'h01;

    // cpu vector addresses
    localparam logic [15:0] STACK_VECTOR_ADDR = 16'h0000;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
    localparam logic [15:0] BREAK_VECTOR_ADDR = 16'h0004;
    localparam logic [1:0]  BREAK_LEVEL_LIMIT = 2'h1;

    // reset pulse length in cycles, and overflows needed for a watchdog reset
    localparam int RESET_HOLD_CYCLES = 4;
    localparam int WATCHDOG_OVERFLOWS = 2;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_PIN,
        SRC_POWER_ON,
        SRC_WATCHDOG,
        SRC_SUPERVISOR,
        SRC_DETECTOR,
        SRC_BREAK
    } reset_source_e;

    typedef struct packed {
        logic       powerCircuit;
        logic       specialRegs;
        logic       cpu;
        logic [15:0] vectorAddr;
        logic [15:0] stackAddr;
    } reset_action_s;

    typedef struct packed {
        logic pinLow;
        logic powerOn;
        logic watchdogOverflow;
        logic supervisorTrip;
        logic detectorTrip;
        logic breakInstruction;
    } reset_request_s;

endpackage

//--- verilog/reset_source_arbiter.sv
module reset_source_arbiter
    import reset_cause_pkg::*;
(
    input  wire reset_cause_pkg::reset_request_s req,
    input  wire logic                            watchdogArmed,
    input  wire logic                            supervisorEnabled,
    input  wire logic                            detectorEnabled,
    output reset_cause_pkg::reset_source_e       source
);
    // fixed priority: hardware causes over the break instruction
    always_comb begin
        source = SRC_NONE;
        if (req.powerOn) begin
            source = SRC_POWER_ON;
        end else if (req.pinLow) begin
            source = SRC_PIN;
        end else if (req.watchdogOverflow && watchdogArmed) begin
            source = SRC_WATCHDOG;
        end else if (req.supervisorTrip && supervisorEnabled) begin
            source = SRC_SUPERVISOR;
        end else if (req.detectorTrip && detectorEnabled) begin
            source = SRC_DETECTOR;
        end else if (req.breakInstruction) begin
            source = SRC_BREAK;
        end
    end
endmodule

//--- verilog/system_reset_cause_controller.sv
module system_reset_cause_controller
    import reset_cause_pkg::*;
(
    input  wire logic                            core_clk,
    input  wire logic                            resetn,
    input  wire logic [15:0]                     avs_address,
    input  wire logic                            avs_read,
    input  wire logic                            avs_write,
    input  wire logic [31:0]                     avs_writedata,
    input  wire logic [3:0]                      avs_byteenable,
    output logic [31:0]                          avs_readdata,
    output logic                                 avs_waitrequest,
    input  wire reset_cause_pkg::reset_request_s resetReq,
    input  wire logic [1:0]                      interruptLevel,
    output logic                                 systemReset,
    output logic                                 powerCircuitInit,
    output logic                                 specialRegInit,
    output logic                                 cpuInit,
    output logic [15:0]                          stackVectorAddr,
    output logic [15:0]                          pcVectorAddr,
    output logic                                 supervisorEnable,
    output logic                                 detectorEnable
);
    import reset_cause_pkg::*;

    // reset release
    logic                  rstSync1;
    logic                  rstSync2;
    // register state
    logic [7:0]            causeStatus_reg;
    logic [7:0]            supervisorMode_reg;
    logic [7:0]            blockControl45_reg;
    logic                  watchdogArmed_reg;
    logic [2:0]            holdCount_reg;
    reset_source_e         activeSource_reg;
    reset_source_e         source;
    // bus and cause decode
    logic                  busAck_reg;
    logic                  busWrite;
    logic                  sourceTaken;
    logic [7:0]            causeSet;
    logic [7:0]            causeStatus_next;

    // sequencer states: hold drives the init strobes
    typedef enum logic [1:0] {RUN, HOLD, RELEASE} seq_state_e;
    seq_state_e            state_reg;

    // the two-flop release avoids a runt reset on deassertion
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // arbiter sees the registered enables, so a fresh enable counts a cycle later
    reset_source_arbiter arbiter (
        .req               (resetReq),
        .watchdogArmed     (watchdogArmed_reg),
        .supervisorEnabled (supervisorEnable),
        .detectorEnabled   (detectorEnable),
        .source            (source)
    );

    // byte-lane merge for a write to an 8-bit register
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
                                              input logic [3:0] be, input logic [15:0] addr);
        logic [7:0] lane;
        lane = data[8*addr[1:0] +: 8];
        merge_byte = be[addr[1:0]] ? lane : old;
    endfunction

    // word match: each register owns a whole 32-bit word
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] regAddr);
        addr_hit = addr[15:2] == regAddr[15:2];
    endfunction

    // first overflow only arms, second resets
    // an overflow that lands inside a hold is dropped, unless the hold is for a break, where a first overflow still arms
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            watchdogArmed_reg <= 1'b0;
        end else if (state_reg == HOLD && activeSource_reg != SRC_BREAK) begin
            watchdogArmed_reg <= 1'b0;
        end else if (resetReq.watchdogOverflow && !watchdogArmed_reg) begin
            watchdogArmed_reg <= 1'b1;
        end
    end

    // sequencer: a new source is caught only while running
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            state_reg        <= HOLD;
            activeSource_reg <= SRC_POWER_ON;
            holdCount_reg    <= 3'h0;
        end else begin
            unique case (state_reg)
                RUN: begin
                    if (source != SRC_NONE) begin
                        state_reg        <= HOLD;
                        activeSource_reg <= source;
                        holdCount_reg    <= 3'h0;
                    end
                end
                // causes arriving now are not queued
                HOLD: begin
                    if (holdCount_reg == 3'(RESET_HOLD_CYCLES - 1)) begin
                        state_reg <= RELEASE;
                    end else begin
                        holdCount_reg <= holdCount_reg + 3'h1;
                    end
                end
                RELEASE: begin
                    state_reg        <= RUN;
                    activeSource_reg <= SRC_NONE;
                end
                // illegal code: fall back into hold; the hold count is not restarted
                default: begin
                    state_reg <= HOLD;
                end
            endcase
        end
    end

    // cause flags raised on entering hold
    always_comb begin
        causeSet = 8'h00;
        if (state_reg == RUN) begin
            unique case (source)
                SRC_POWER_ON:   causeSet[POWER_ON_BIT] = 1'b1;
                SRC_WATCHDOG:   causeSet[WATCHDOG_BIT] = 1'b1;
                SRC_SUPERVISOR: causeSet[SUPERVISOR_BIT] = 1'b1;
                SRC_DETECTOR:   causeSet[DETECTOR_BIT] = 1'b1;
                SRC_PIN, SRC_BREAK, SRC_NONE: causeSet = 8'h00;
            endcase
        end
    end

    // writes land at the edge that ends the cycle after the wait state, as the master expects
    assign busWrite = avs_write && busAck_reg;

    // a cause is taken only while running; one arriving in hold is lost
    assign sourceTaken = state_reg == RUN && source != SRC_NONE;

    // never cleared by a source reset; set by causes, and a bus write replaces the byte
    always_comb begin
        causeStatus_next = causeStatus_reg;
        if (busWrite && addr_hit(avs_address, CAUSE_STATUS_ADDR)) begin
            causeStatus_next = merge_byte(causeStatus_reg, avs_writedata, avs_byteenable, CAUSE_STATUS_ADDR)
                               & CAUSE_MASK;
        end
        causeStatus_next = causeStatus_next | causeSet;
    end

    // power-on is the only reset reaching this flop; its value is power-on
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            causeStatus_reg <= CAUSE_POWER_ON_VALUE;
        end else begin
            causeStatus_reg <= causeStatus_next;
        end
    end

    // enable registers, written by software, reset by sources
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            supervisorMode_reg <= SUPERVISOR_MODE_RESET;
            blockControl45_reg <= BLOCK_CONTROL_45_RESET;
        end else if (sourceTaken) begin
            // keep own enable, reset the other
            if (source != SRC_SUPERVISOR) begin
                supervisorMode_reg <= SUPERVISOR_MODE_RESET;
            end
            if (source != SRC_DETECTOR) begin
                blockControl45_reg <= BLOCK_CONTROL_45_RESET;
            end
        end else if (busWrite) begin
            if (addr_hit(avs_address, SUPERVISOR_MODE_ADDR)) begin
                supervisorMode_reg <= merge_byte(supervisorMode_reg, avs_writedata, avs_byteenable,
                                                 SUPERVISOR_MODE_ADDR);
            end
            if (addr_hit(avs_address, BLOCK_CONTROL_45_ADDR)) begin
                blockControl45_reg <= merge_byte(blockControl45_reg, avs_writedata, avs_byteenable,
                                                 BLOCK_CONTROL_45_ADDR);
            end
        end
    end

    // one wait state on every access, ack pulses one cycle
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            busAck_reg <= 1'b0;
        end else begin
            busAck_reg <= (avs_read || avs_write) && !busAck_reg;
        end
    end

    // own flop so the pin comes straight from a register; mirrors !busAck_reg
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !busAck_reg);
        end
    end

    // read data latched on the first cycle; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !busAck_reg) begin
            avs_readdata <= 32'h0000_0000;
            unique case (avs_address[15:2])
                CAUSE_STATUS_ADDR[15:2]:
                    avs_readdata[8*CAUSE_STATUS_ADDR[1:0] +: 8] <= causeStatus_reg;
                SUPERVISOR_MODE_ADDR[15:2]:
                    avs_readdata[8*SUPERVISOR_MODE_ADDR[1:0] +: 8] <= supervisorMode_reg;
                BLOCK_CONTROL_45_ADDR[15:2]:
                    avs_readdata[8*BLOCK_CONTROL_45_ADDR[1:0] +: 8] <= blockControl45_reg;
                RESET_CONTROL_ADDR[15:2]:
                    avs_readdata[2:0] <= 3'(activeSource_reg);
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // initialisation strobes, held for the whole hold phase; a break hold raises only systemReset and cpuInit
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            systemReset      <= 1'b1;
            powerCircuitInit <= 1'b1;
            specialRegInit   <= 1'b1;
            cpuInit          <= 1'b1;
        end else begin
            systemReset      <= state_reg == HOLD;
            powerCircuitInit <= state_reg == HOLD && activeSource_reg != SRC_BREAK;
            specialRegInit   <= state_reg == HOLD && activeSource_reg != SRC_BREAK;
            cpuInit          <= state_reg == HOLD;
        end
    end

    // vector choice for break at low level
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            stackVectorAddr <= STACK_VECTOR_ADDR;
            pcVectorAddr    <= RESET_VECTOR_ADDR;
        end else if (sourceTaken) begin
            stackVectorAddr <= STACK_VECTOR_ADDR;
            pcVectorAddr    <= (source == SRC_BREAK && interruptLevel <= BREAK_LEVEL_LIMIT)
                               ? BREAK_VECTOR_ADDR : RESET_VECTOR_ADDR;
        end
    end

    // no data memory init path
    // enables follow the mode bits one cycle later
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            supervisorEnable <= 1'b0;
            detectorEnable   <= 1'b0;
        end else begin
            supervisorEnable <= supervisorMode_reg[SUPERVISOR_ENABLE_BIT];
            detectorEnable   <= !blockControl45_reg[DETECTOR_DISABLE_BIT];
        end
    end
endmodule

//--- tb/system_reset_cause_controller_chk.sv
module system_reset_cause_controller_chk
    import reset_cause_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [15:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  interruptLevel,
    input wire logic        powerCircuitInit,
    input wire logic        specialRegInit,
    input wire logic        cpuInit,
    input wire logic [15:0] stackVectorAddr,
    input wire logic [15:0] pcVectorAddr,
    input wire logic        supervisorEnable,
    input wire logic        detectorEnable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // init groups nest: power implies registers implies cpu
    property p_power_regs; powerCircuitInit |-> specialRegInit; endproperty
    a_power_regs: assert property (p_power_regs) else $error("power init without register init");
    property p_regs_cpu; specialRegInit |-> cpuInit; endproperty
    a_regs_cpu: assert property (p_regs_cpu) else $error("register init without cpu init");
    // vectors while the cpu is held
    property p_stack; cpuInit |-> stackVectorAddr == STACK_VECTOR_ADDR; endproperty
    a_stack: assert property (p_stack) else $error("stack vector wrong");
    property p_pc_full; cpuInit && powerCircuitInit |-> pcVectorAddr == RESET_VECTOR_ADDR; endproperty
    a_pc_full: assert property (p_pc_full) else $error("pc vector wrong on full reset");
    property p_pc_break;
        $rose(cpuInit) && !powerCircuitInit |->
            pcVectorAddr == ((interruptLevel <= BREAK_LEVEL_LIMIT) ? BREAK_VECTOR_ADDR : RESET_VECTOR_ADDR);
    endproperty
    a_pc_break: assert property (p_pc_break) else $error("pc vector wrong on break");
    // hold is a fixed four-cycle window
    property p_hold; $rose(cpuInit) |-> cpuInit[*4] ##1 !cpuInit; endproperty
    a_hold: assert property (p_hold) else $error("reset hold length wrong");
    // enables come on only through a write, two cycles after it lands
    property p_sup_on;
        $rose(supervisorEnable) |-> $past(avs_write && avs_address == SUPERVISOR_MODE_ADDR, 2);
    endproperty
    a_sup_on: assert property (p_sup_on) else $error("supervisor enabled without write");
    property p_det_on;
        $rose(detectorEnable) |-> $past(avs_write && avs_address == BLOCK_CONTROL_45_ADDR, 2);
    endproperty
    a_det_on: assert property (p_det_on) else $error("detector enabled without write");
    property p_sup_off; $fell(supervisorEnable) |-> $past(avs_write) or ##[0:3] cpuInit; endproperty
    a_sup_off: assert property (p_sup_off) else $error("supervisor disabled without cause");
    // slave answers one cycle after taking a request
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    c_break: cover property ($rose(cpuInit) && !powerCircuitInit);
    c_sup: cover property ($rose(supervisorEnable));
    c_write: cover property (!avs_waitrequest && avs_write);
endmodule

//--- tb/system_reset_cause_controller_tb_top.sv
module system_reset_cause_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import reset_cause_pkg::*;

    logic           core_clk = 1'b0;
    logic           resetn = 1'b0;
    logic [15:0]    avs_address = 16'h0000;
    logic           avs_read = 1'b0;
    logic           avs_write = 1'b0;
    logic [31:0]    avs_writedata = 32'h0000_0000;
    logic [3:0]     avs_byteenable = 4'h1;
    logic [31:0]    avs_readdata, rd, v;
    logic           avs_waitrequest, systemReset, powerCircuitInit, specialRegInit, cpuInit;
    reset_request_s resetReq = '0;
    logic [1:0]     interruptLevel = 2'h0;
    logic [15:0]    stackVectorAddr, pcVectorAddr, pcSeen;
    logic           supervisorEnable, detectorEnable;
    logic [3:0]     seen;
    int             bad_count = 0, compares = 0, seed = 32'hb257;
    int             expStatus = 1, expSup = 0, expDet = 0, wdArmed = 0;

    system_reset_cause_controller u_dut (
        .core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .resetReq, .interruptLevel, .systemReset, .powerCircuitInit,
        .specialRegInit, .cpuInit, .stackVectorAddr, .pcVectorAddr, .supervisorEnable, .detectorEnable
    );

    // free-running core clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low, bounded so a hang ends the run
    task automatic busOp(input logic wrEn, input logic [15:0] addr, input logic [31:0] data);
        int n;
        @(posedge core_clk);
        avs_address   <= addr;
        avs_writedata <= data;
        avs_read      <= ~wrEn;
        avs_write     <= wrEn;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) begin
            bad_count++;
            $display("ERROR %0t bus timeout", $time);
            wrap_up();
        end
    endtask

    task automatic rdChk(input logic [15:0] addr, input logic [31:0] exp);
        busOp(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic enableBoth();
        busOp(1'b1, SUPERVISOR_MODE_ADDR, 32'h0000_0001);
        busOp(1'b1, BLOCK_CONTROL_45_ADDR, 32'h0000_0000);
        expSup = 1;
        expDet = 1;
        repeat (2) @(posedge core_clk);
        check(32'({supervisorEnable, detectorEnable}), 3);
    endtask

    // one-cycle request on source idx, then watch the whole hold window against the model
    task automatic src(input int idx);
        int taken;
        taken = (idx == 3) ? wdArmed : (idx == 2) ? expSup : (idx == 1) ? expDet : 1;
        @(posedge core_clk);
        resetReq <= reset_request_s'(6'h01 << idx);
        @(posedge core_clk);
        resetReq <= '0;
        seen = 3'h0;
        pcSeen = 16'h0000;
        repeat (12) begin
            @(posedge core_clk);
            seen |= {systemReset, powerCircuitInit, specialRegInit, cpuInit};
            if (cpuInit === 1'b1) pcSeen = pcVectorAddr;
        end
        if (idx == 3 && taken == 0) wdArmed = 1;
        if (taken != 0) begin
            expStatus |= (idx == 4) ? 1 : (idx == 3) ? 4 : (idx == 2) ? 8 : (idx == 1) ? 16 : 0;
            if (idx != 0) wdArmed = 0;
            if (idx != 2) expSup = 0;
            if (idx != 1) expDet = 0;
        end
        check(32'(seen), (taken == 0) ? 0 : (idx == 0) ? 9 : 15);
        if (taken != 0) check(32'(pcSeen), (idx == 0 && interruptLevel <= 1) ? 4 : 2);
        check(32'({supervisorEnable, detectorEnable}), 32'({expSup[0], expDet[0]}));
        rdChk(CAUSE_STATUS_ADDR, expStatus);
    endtask

    // main sequence: power-on state, register access, then every reset source
    initial begin
        repeat (16) @(posedge core_clk);
        check(32'({systemReset, powerCircuitInit, specialRegInit, cpuInit}), 15);
        check({stackVectorAddr, pcVectorAddr}, {STACK_VECTOR_ADDR, RESET_VECTOR_ADDR});
        resetn <= 1'b1;
        repeat (10) @(posedge core_clk);
        rdChk(CAUSE_STATUS_ADDR, 32'(CAUSE_POWER_ON_VALUE));
        rdChk(SUPERVISOR_MODE_ADDR, 32'(SUPERVISOR_MODE_RESET));
        rdChk(BLOCK_CONTROL_45_ADDR, 32'(BLOCK_CONTROL_45_RESET));
        rdChk(16'hf020, 32'h0000_0000);
        rdChk(RESET_CONTROL_ADDR, 32'(SRC_NONE));
        repeat (4) begin
            v = $random(seed);
            avs_byteenable <= v[11:8];
            busOp(1'b1, CAUSE_STATUS_ADDR, v);
            if (v[8]) expStatus = v & 32'(CAUSE_MASK);
            rdChk(CAUSE_STATUS_ADDR, expStatus);
        end
        avs_byteenable <= 4'h1;
        busOp(1'b1, CAUSE_STATUS_ADDR, 32'h0000_0000);
        expStatus = 0;
        src(5);
        src(2);
        src(1);
        src(3);
        src(3);
        enableBoth();
        src(2);
        enableBoth();
        src(1);
        enableBoth();
        interruptLevel <= 2'h1;
        src(0);
        interruptLevel <= 2'h2;
        src(0);
        src(4);
        wrap_up();
    end
endmodule

bind system_reset_cause_controller system_reset_cause_controller_chk u_chk (
    .core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_waitrequest, .interruptLevel,
    .powerCircuitInit, .specialRegInit, .cpuInit, .stackVectorAddr, .pcVectorAddr,
    .supervisorEnable, .detectorEnable
);
